/* File: verilog/dxd_pkg.sv */
// Opcode fields, register numbers, steps and carriers of the decoder.
// Assumes one aligned 32-bit fetch word per instruction.
// Contract
// - Double group of 14 codes, single group of 16 codes
// - 32-bit parallel word, double transfer in field A
// - Standalone double and single transfers are 16 bits
// - Double transfer issues X and Y access together
// - X uses x_pointer, Y uses y_pointer
// - Double transfers reach only X and Y memory
// - Single transfers use general bus, pointer R2 to R5
// - X idle: no X access, no register change
// - Y idle: no Y access, no register change
// - Load puts word in upper half, clears lower half; long single loads take all 32 bits
// - Mode 10 adds 2 to the pointer after access; long single moves add 4
// - Mode 11 adds the step index after access
// - Store writes upper half of accumulator source
// - Store-system: Rn minus 4, then DSP register to (Rn)
// - DSP register stores decode only on the DSP variant
// - x_pointer R4/R5, y_pointer R6/R7, step indices R8 and R9
// - X target X0/X1, Y target Y0/Y1, accumulator source A0/A1
package dxd_pkg;
    // Opcode prefixes
    localparam logic [5:0] DOUBLE_PREFIX = 6'h3c;
    localparam logic [5:0] SINGLE_PREFIX = 6'h3d;
    localparam logic [5:0] PARALLEL_PREFIX = 6'h3e;
    localparam logic [3:0] SYS_STORE_TOP = 4'h4;
    localparam logic [3:0] SYS_STORE_LOW = 4'h2;
    // Access-mode field values
    localparam logic [1:0] MODE_IDLE = 2'h0;
    localparam logic [1:0] MODE_PLAIN = 2'h1;
    localparam logic [1:0] MODE_INC = 2'h2;
    localparam logic [1:0] MODE_INDEX = 2'h3;
    localparam logic [1:0] SMODE_PREDEC = 2'h0;
    // General register numbers
    localparam logic [3:0] GR_R2 = 4'h2;
    localparam logic [3:0] GR_R3 = 4'h3;
    localparam logic [3:0] GR_R4 = 4'h4;
    localparam logic [3:0] GR_R5 = 4'h5;
    localparam logic [3:0] GR_R6 = 4'h6;
    localparam logic [3:0] GR_R7 = 4'h7;
    localparam logic [3:0] GR_X_STEP = 4'h8;
    localparam logic [3:0] GR_Y_STEP = 4'h9;
    // DSP register copies
    localparam logic [2:0] DR_X0 = 3'h0;
    localparam logic [2:0] DR_X1 = 3'h1;
    localparam logic [2:0] DR_Y0 = 3'h2;
    localparam logic [2:0] DR_Y1 = 3'h3;
    localparam logic [2:0] DR_A0 = 3'h4;
    localparam logic [2:0] DR_A1 = 3'h5;
    localparam int DR_COUNT = 6;
    // Store-system field codes, bits 7:4
    localparam logic [3:0] SYS_A0 = 4'h7;
    localparam logic [3:0] SYS_X0 = 4'h8;
    localparam logic [3:0] SYS_X1 = 4'h9;
    localparam logic [3:0] SYS_Y0 = 4'ha;
    localparam logic [3:0] SYS_Y1 = 4'hb;
    // Single transfer register field, bits 7:4
    localparam logic [3:0] DS_A1 = 4'h5;
    localparam logic [3:0] DS_A0 = 4'h7;
    localparam logic [3:0] DS_X0 = 4'h8;
    localparam logic [3:0] DS_X1 = 4'h9;
    localparam logic [3:0] DS_Y0 = 4'ha;
    localparam logic [3:0] DS_Y1 = 4'hb;
    // Pointer steps and reset values
    localparam logic [31:0] STEP_WORD = 32'h2;
    localparam logic [31:0] STEP_LONG = 32'h4;
    localparam logic [31:0] REG_RESET = 32'h0;

    typedef struct packed {
        logic re;
        logic we;
        logic [31:0] addr;
        logic [15:0] wdata;
    } dxd_xy_req_t;

    typedef struct packed {
        logic re;
        logic we;
        logic long_size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } dxd_bus_req_t;

    typedef struct packed {
        logic pend;
        logic long_size;
        logic [2:0] tgt;
    } dxd_load_t;
endpackage

/* File: verilog/dxd_decode.sv */
// DSP transfer decoder: X/Y double moves, single moves, stack stores.
// Assumes memories answer one cycle after a request; owners write
// the register copies through the write ports.
`timescale 1ns/1ps
module dxd_decode #(
    parameter bit DSP_PRESENT = 1'b1
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic gr_we,
    input wire logic [3:0] gr_widx,
    input wire logic [31:0] gr_wdata,
    input wire logic dr_we,
    input wire logic [2:0] dr_widx,
    input wire logic [31:0] dr_wdata,
    input wire logic [15:0] xmem_rdata,
    input wire logic [15:0] ymem_rdata,
    input wire logic [31:0] sbus_rdata,
    output dxd_pkg::dxd_xy_req_t xmem_req,
    output dxd_pkg::dxd_xy_req_t ymem_req,
    output dxd_pkg::dxd_bus_req_t sbus_req,
    output logic parallel_len,
    output logic [15:0] field_b,
    output logic xfer_done,
    output logic xfer_bad
);
    logic [31:0] gr_reg [0:15];
    logic [31:0] gr_next [0:15];
    logic [31:0] dr_reg [0:dxd_pkg::DR_COUNT-1];
    logic [31:0] dr_next [0:dxd_pkg::DR_COUNT-1];
    dxd_pkg::dxd_xy_req_t x_reg, x_next, y_reg, y_next;
    dxd_pkg::dxd_bus_req_t s_reg, s_next;
    dxd_pkg::dxd_load_t xl_reg, xl_next, yl_reg, yl_next;
    dxd_pkg::dxd_load_t sl_reg, sl_next;
    dxd_pkg::dxd_load_t xw_reg, yw_reg, sw_reg;
    logic par_reg, par_next, done_reg, done_next, bad_reg, bad_next;
    logic [15:0] fb_reg, fb_next;

    // Single move register code to local copy index
    function automatic logic [3:0] ds_map(input logic [3:0] code);
        logic [3:0] r;
        unique case (code)
            dxd_pkg::DS_X0: r = {1'b0, dxd_pkg::DR_X0};
            dxd_pkg::DS_X1: r = {1'b0, dxd_pkg::DR_X1};
            dxd_pkg::DS_Y0: r = {1'b0, dxd_pkg::DR_Y0};
            dxd_pkg::DS_Y1: r = {1'b0, dxd_pkg::DR_Y1};
            dxd_pkg::DS_A0: r = {1'b0, dxd_pkg::DR_A0};
            dxd_pkg::DS_A1: r = {1'b0, dxd_pkg::DR_A1};
            default: r = 4'h8;
        endcase
        return r;
    endfunction

    // Store-system field to local copy index
    function automatic logic [3:0] sys_map(input logic [3:0] code);
        logic [3:0] r;
        unique case (code)
            dxd_pkg::SYS_A0: r = {1'b0, dxd_pkg::DR_A0};
            dxd_pkg::SYS_X0: r = {1'b0, dxd_pkg::DR_X0};
            dxd_pkg::SYS_X1: r = {1'b0, dxd_pkg::DR_X1};
            dxd_pkg::SYS_Y0: r = {1'b0, dxd_pkg::DR_Y0};
            dxd_pkg::SYS_Y1: r = {1'b0, dxd_pkg::DR_Y1};
            default: r = 4'h8;
        endcase
        return r;
    endfunction

    // Decode, pointer update and load write-back
    always_comb
    begin
        logic [15:0] op;
        logic [3:0] xptr, yptr, sptr, sel;
        logic [1:0] xmode, ymode, smode;
        logic [31:0] step, base;
        logic long_op;
        op = 16'h0;
        xptr = 4'h0;
        yptr = 4'h0;
        sptr = 4'h0;
        sel = 4'h0;
        xmode = 2'h0;
        ymode = 2'h0;
        smode = 2'h0;
        step = 32'h0;
        base = 32'h0;
        long_op = 1'b0;
        gr_next = gr_reg;
        dr_next = dr_reg;
        x_next = '0;
        y_next = '0;
        s_next = '0;
        xl_next = '0;
        yl_next = '0;
        sl_next = '0;
        par_next = 1'b0;
        done_next = 1'b0;
        bad_next = 1'b0;
        fb_next = fb_reg;
        // Owner writes first; this block's updates win
        if (gr_we)
        begin
            gr_next[gr_widx] = gr_wdata;
        end
        if (dr_we)
        begin
            dr_next[dr_widx] = dr_wdata;
        end
        // Returning loads: upper half from memory, lower half cleared; long single loads take all 32 bits
        if (xw_reg.pend)
        begin
            dr_next[xw_reg.tgt] = {xmem_rdata, 16'h0};
        end
        if (yw_reg.pend)
        begin
            dr_next[yw_reg.tgt] = {ymem_rdata, 16'h0};
        end
        if (sw_reg.pend)
        begin
            dr_next[sw_reg.tgt] = sw_reg.long_size ? sbus_rdata
                                  : {sbus_rdata[15:0], 16'h0};
        end
        if (instr_valid)
        begin
            // Field A sits above the DSP operation
            if (instr_word[31:26] == dxd_pkg::PARALLEL_PREFIX)
            begin
                op = {dxd_pkg::DOUBLE_PREFIX, instr_word[25:16]};
                par_next = 1'b1;
                fb_next = instr_word[15:0];
            end
            else
            begin
                op = instr_word[31:16];
            end
            xptr = op[9] ? dxd_pkg::GR_R5 : dxd_pkg::GR_R4;
            yptr = op[8] ? dxd_pkg::GR_R7 : dxd_pkg::GR_R6;
            xmode = op[3:2];
            ymode = op[1:0];
            if (op[15:10] == dxd_pkg::DOUBLE_PREFIX)
            begin
                done_next = 1'b1;
                // X half, decoded apart from the Y half
                if (xmode != dxd_pkg::MODE_IDLE)
                begin
                    x_next.addr = gr_reg[xptr];
                    if (op[5])
                    begin
                        x_next.we = 1'b1;
                        x_next.wdata = op[7] ? dr_reg[dxd_pkg::DR_A1][31:16]
                                       : dr_reg[dxd_pkg::DR_A0][31:16];
                    end
                    else
                    begin
                        x_next.re = 1'b1;
                        xl_next.pend = 1'b1;
                        xl_next.tgt = op[7] ? dxd_pkg::DR_X1
                                      : dxd_pkg::DR_X0;
                    end
                    if (xmode == dxd_pkg::MODE_INC)
                    begin
                        gr_next[xptr] = gr_reg[xptr] + dxd_pkg::STEP_WORD;
                    end
                    else if (xmode == dxd_pkg::MODE_INDEX)
                    begin
                        gr_next[xptr] = gr_reg[xptr]
                                        + gr_reg[dxd_pkg::GR_X_STEP];
                    end
                end
                // Y half issues in the same cycle as the X half
                if (ymode != dxd_pkg::MODE_IDLE)
                begin
                    y_next.addr = gr_reg[yptr];
                    if (op[4])
                    begin
                        y_next.we = 1'b1;
                        y_next.wdata = op[6] ? dr_reg[dxd_pkg::DR_A1][31:16]
                                       : dr_reg[dxd_pkg::DR_A0][31:16];
                    end
                    else
                    begin
                        y_next.re = 1'b1;
                        yl_next.pend = 1'b1;
                        yl_next.tgt = op[6] ? dxd_pkg::DR_Y1
                                      : dxd_pkg::DR_Y0;
                    end
                    if (ymode == dxd_pkg::MODE_INC)
                    begin
                        gr_next[yptr] = gr_reg[yptr] + dxd_pkg::STEP_WORD;
                    end
                    else if (ymode == dxd_pkg::MODE_INDEX)
                    begin
                        gr_next[yptr] = gr_reg[yptr]
                                        + gr_reg[dxd_pkg::GR_Y_STEP];
                    end
                end
            end
            else if (op[15:10] == dxd_pkg::SINGLE_PREFIX)
            begin
                // Single move: any address, four selectable pointers
                unique case (op[9:8])
                    2'h0: sptr = dxd_pkg::GR_R4;
                    2'h1: sptr = dxd_pkg::GR_R5;
                    2'h2: sptr = dxd_pkg::GR_R2;
                    2'h3: sptr = dxd_pkg::GR_R3;
                endcase
                sel = ds_map(op[7:4]);
                smode = op[3:2];
                long_op = op[1];
                step = long_op ? dxd_pkg::STEP_LONG : dxd_pkg::STEP_WORD;
                if (sel[3])
                begin
                    bad_next = 1'b1; // Register not held in this block
                end
                else
                begin
                    done_next = 1'b1;
                    base = gr_reg[sptr];
                    if (smode == dxd_pkg::SMODE_PREDEC)
                    begin
                        base = gr_reg[sptr] - step;
                        gr_next[sptr] = base;
                    end
                    else if (smode == dxd_pkg::MODE_INC)
                    begin
                        gr_next[sptr] = gr_reg[sptr] + step;
                    end
                    else if (smode == dxd_pkg::MODE_INDEX)
                    begin
                        gr_next[sptr] = gr_reg[sptr]
                                        + gr_reg[dxd_pkg::GR_X_STEP];
                    end
                    s_next.addr = base;
                    s_next.long_size = long_op;
                    if (op[0])
                    begin
                        s_next.we = 1'b1;
                        s_next.wdata = long_op ? dr_reg[sel[2:0]]
                                       : {16'h0, dr_reg[sel[2:0]][31:16]};
                    end
                    else
                    begin
                        s_next.re = 1'b1;
                        sl_next.pend = 1'b1;
                        sl_next.long_size = long_op;
                        sl_next.tgt = sel[2:0];
                    end
                end
            end
            else if (DSP_PRESENT && op[15:12] == dxd_pkg::SYS_STORE_TOP
                     && op[3:0] == dxd_pkg::SYS_STORE_LOW
                     && sys_map(op[7:4]) != 4'h8)
            begin
                // Pre-decrement by 4, then store the whole DSP register
                sel = sys_map(op[7:4]);
                base = gr_reg[op[11:8]] - dxd_pkg::STEP_LONG;
                gr_next[op[11:8]] = base;
                s_next.we = 1'b1;
                s_next.long_size = 1'b1;
                s_next.addr = base;
                s_next.wdata = dr_reg[sel[2:0]];
                done_next = 1'b1;
            end
            else if (op[15:12] == 4'hf)
            begin
                bad_next = 1'b1; // DSP space code this block does not own
            end
        end
    end

    // Register stage; every output is one of these flops
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < 16; i++)
            begin
                gr_reg[i] <= dxd_pkg::REG_RESET;
            end
            for (int i = 0; i < dxd_pkg::DR_COUNT; i++)
            begin
                dr_reg[i] <= dxd_pkg::REG_RESET;
            end
            x_reg <= '0;
            y_reg <= '0;
            s_reg <= '0;
            xl_reg <= '0;
            yl_reg <= '0;
            sl_reg <= '0;
            xw_reg <= '0;
            yw_reg <= '0;
            sw_reg <= '0;
            par_reg <= 1'b0;
            done_reg <= 1'b0;
            bad_reg <= 1'b0;
            fb_reg <= 16'h0;
        end
        else
        begin
            gr_reg <= gr_next;
            dr_reg <= dr_next;
            x_reg <= x_next;
            y_reg <= y_next;
            s_reg <= s_next;
            xl_reg <= xl_next;
            yl_reg <= yl_next;
            sl_reg <= sl_next;
            xw_reg <= xl_reg;
            yw_reg <= yl_reg;
            sw_reg <= sl_reg;
            par_reg <= par_next;
            done_reg <= done_next;
            bad_reg <= bad_next;
            fb_reg <= fb_next;
        end
    end

    assign xmem_req = x_reg;
    assign ymem_req = y_reg;
    assign sbus_req = s_reg;
    assign parallel_len = par_reg;
    assign field_b = fb_reg;
    assign xfer_done = done_reg;
    assign xfer_bad = bad_reg;
endmodule

/* File: verification/dxd_decode_sva.sv */
// Checker for the DSP transfer decoder: request timing seen at its ports.
// Assumes the store-system decode is present and answers one edge after.
`timescale 1ns/1ps
module dxd_decode_sva (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic gr_we,
    input wire dxd_pkg::dxd_xy_req_t xmem_req,
    input wire dxd_pkg::dxd_xy_req_t ymem_req,
    input wire dxd_pkg::dxd_bus_req_t sbus_req,
    input wire logic parallel_len,
    input wire logic [15:0] field_b,
    input wire logic xfer_done,
    input wire logic xfer_bad
);
    logic par, dbl, sys, sgl;
    // Instruction classes decoded from the taken word
    assign par = instr_valid && instr_word[31:26] == dxd_pkg::PARALLEL_PREFIX;
    assign dbl = par || (instr_valid
        && instr_word[31:26] == dxd_pkg::DOUBLE_PREFIX);
    assign sys = instr_valid && instr_word[31:28] == dxd_pkg::SYS_STORE_TOP
        && instr_word[19:16] == dxd_pkg::SYS_STORE_LOW
        && instr_word[23:20] >= dxd_pkg::SYS_A0
        && instr_word[23:20] <= dxd_pkg::SYS_Y1;
    assign sgl = instr_valid && instr_word[31:26] == dxd_pkg::SINGLE_PREFIX;
    default clocking dc @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // Back-to-back takes through one pointer
    sequence s_x_inc_pair;
        dbl && instr_word[19:18] == dxd_pkg::MODE_INC && !gr_we ##1
        dbl && instr_word[19:18] != dxd_pkg::MODE_IDLE && !gr_we
        && instr_word[25] == $past(instr_word[25]);
    endsequence
    sequence s_sys_pair;
        sys && !gr_we ##1 sys && !gr_we
        && instr_word[27:24] == $past(instr_word[27:24]);
    endsequence
    property p_par_len;
        par |=> parallel_len && xfer_done
            && field_b == $past(instr_word[15:0]);
    endproperty
    a_par_len: assert property (p_par_len)
        else $error("parallel word not flagged");
    property p_single;
        sgl && instr_word[23:20] != 4'h0 |=> !parallel_len && xfer_done
            && (sbus_req.re ^ sbus_req.we) && !xmem_req.re && !ymem_req.re;
    endproperty
    a_single: assert property (p_single)
        else $error("single move request wrong");
    property p_x_idle;
        dbl && instr_word[19:18] == dxd_pkg::MODE_IDLE
            |=> !xmem_req.re && !xmem_req.we;
    endproperty
    a_x_idle: assert property (p_x_idle)
        else $error("idle X half made an access");
    property p_y_idle;
        dbl && instr_word[17:16] == dxd_pkg::MODE_IDLE
            |=> !ymem_req.re && !ymem_req.we;
    endproperty
    a_y_idle: assert property (p_y_idle)
        else $error("idle Y half made an access");
    property p_x_dir;
        dbl && instr_word[19:18] != dxd_pkg::MODE_IDLE
            |=> xmem_req.we == $past(instr_word[21])
            && xmem_req.re != xmem_req.we;
    endproperty
    a_x_dir: assert property (p_x_dir)
        else $error("X access direction wrong");
    property p_y_dir;
        dbl && instr_word[17:16] != dxd_pkg::MODE_IDLE
            |=> ymem_req.we == $past(instr_word[20])
            && ymem_req.re != ymem_req.we;
    endproperty
    a_y_dir: assert property (p_y_dir)
        else $error("Y access direction wrong");
    property p_xy_only;
        dbl |=> !sbus_req.re && !sbus_req.we && !xfer_bad;
    endproperty
    a_xy_only: assert property (p_xy_only)
        else $error("double transfer used the general bus");
    property p_x_inc;
        s_x_inc_pair |=> xmem_req.addr == $past(xmem_req.addr) + 32'h2;
    endproperty
    a_x_inc: assert property (p_x_inc)
        else $error("X pointer not advanced by two");
    property p_sys_st;
        sys |=> sbus_req.we && sbus_req.long_size
            && !xmem_req.we && !ymem_req.we;
    endproperty
    a_sys_st: assert property (p_sys_st)
        else $error("store-system did not write long");
    property p_sys_dec;
        s_sys_pair |=> sbus_req.addr == $past(sbus_req.addr) - 32'h4;
    endproperty
    a_sys_dec: assert property (p_sys_dec)
        else $error("stack pointer not lowered by four");
    property p_bad;
        sgl && instr_word[23:20] == 4'h0 |=> xfer_bad && !sbus_req.we;
    endproperty
    a_bad: assert property (p_bad)
        else $error("bad register code not flagged");
endmodule

/* File: verification/dxd_xy_mem_model.sv */
// Behavioural X or Y data memory on the far side of the decoder.
// Assumes one-cycle request pulses; read data stands the cycle after.
`timescale 1ns/1ps
module dxd_xy_mem_model #(
    parameter logic [15:0] FILL = 16'h0
) (
    input wire logic mclk,
    input wire dxd_pkg::dxd_xy_req_t req,
    output logic [15:0] rdata
);
    logic [15:0] mem [logic [31:0]];
    initial rdata = 16'h0;
    // Synchronous array; unwritten words read back as an address pattern
    always @(posedge mclk)
    begin
        if (req.we)
            mem[req.addr] = req.wdata;
        if (req.re && mem.exists(req.addr))
            rdata <= mem[req.addr];
        else if (req.re)
            rdata <= req.addr[16:1] ^ FILL;
        else
            rdata <= ~rdata; // No hold: stale data must not look valid
    end
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench for the DSP transfer decoder with X/Y memory models.
// Assumes requests one edge after the take and load write-back two later.
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        dxd_pkg::dxd_xy_req_t x;
        dxd_pkg::dxd_xy_req_t y;
        dxd_pkg::dxd_bus_req_t s;
        logic plen;
        logic done;
        logic bad;
        logic [15:0] fb;
    } dxd_note_t;
    localparam logic [15:0] XFILL = 16'h3c5a;
    localparam logic [15:0] YFILL = 16'ha5c3;
    logic mclk, arst_n, instr_valid, gr_we, dr_we;
    logic parallel_len, xfer_done, xfer_bad;
    logic [31:0] instr_word, gr_wdata, dr_wdata, sbus_rdata, t;
    logic [3:0] gr_widx;
    logic [2:0] dr_widx;
    logic [15:0] xmem_rdata, ymem_rdata, field_b, fb_last;
    logic [9:0] a;
    dxd_pkg::dxd_xy_req_t xmem_req, ymem_req;
    dxd_pkg::dxd_bus_req_t sbus_req;
    dxd_note_t notes[$];
    dxd_note_t cur, ex;
    logic [31:0] r [16];
    logic [31:0] d [6];
    logic [15:0] xm [logic [31:0]];
    logic [15:0] ym [logic [31:0]];
    logic [31:0] seed = 32'h00017c3a;
    int bad_count, samples_checked;

    dxd_decode #(.DSP_PRESENT(1'b1)) i_dut (.mclk(mclk), .arst_n(arst_n),
        .instr_valid(instr_valid), .instr_word(instr_word), .gr_we(gr_we),
        .gr_widx(gr_widx), .gr_wdata(gr_wdata), .dr_we(dr_we),
        .dr_widx(dr_widx), .dr_wdata(dr_wdata), .xmem_rdata(xmem_rdata),
        .ymem_rdata(ymem_rdata), .sbus_rdata(sbus_rdata), .xmem_req(xmem_req),
        .ymem_req(ymem_req), .sbus_req(sbus_req), .parallel_len(parallel_len),
        .field_b(field_b), .xfer_done(xfer_done), .xfer_bad(xfer_bad));
    dxd_xy_mem_model #(.FILL(XFILL)) i_xmem (.mclk(mclk), .req(xmem_req),
        .rdata(xmem_rdata));
    dxd_xy_mem_model #(.FILL(YFILL)) i_ymem (.mclk(mclk), .req(ymem_req),
        .rdata(ymem_rdata));

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    function automatic logic [31:0] lfsr();
        seed = seed[0] ? (seed >> 1) ^ 32'h80200003 : seed >> 1;
        return seed;
    endfunction
    function automatic logic [15:0] mrd(input bit isy, input logic [31:0] ad);
        if (isy)
            return ym.exists(ad) ? ym[ad] : ad[16:1] ^ YFILL;
        return xm.exists(ad) ? xm[ad] : ad[16:1] ^ XFILL;
    endfunction
    task automatic check(input string what, input dxd_note_t seen,
        input dxd_note_t exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", bad_count, samples_checked);
        if (bad_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n)
        begin
            @(posedge mclk);
            #1 instr_valid = 1'b0;
            gr_we = 1'b0;
            dr_we = 1'b0;
        end
    endtask
    task automatic issue(input logic [31:0] w, input dxd_note_t n, input bit has);
        @(posedge mclk);
        #1 instr_valid = 1'b1;
        instr_word = w;
        gr_we = 1'b0;
        dr_we = 1'b0;
        if (has) notes.push_back(n);
    endtask
    task automatic wr(input logic [3:0] i, input logic [31:0] v, input bit dsp);
        @(posedge mclk);
        #1 instr_valid = 1'b0;
        gr_we = !dsp;
        dr_we = dsp;
        gr_widx = i;
        dr_widx = i[2:0];
        gr_wdata = v;
        dr_wdata = v;
        if (dsp) d[i] = v;
        else r[i] = v;
    endtask
    // Expected request of one half and its effect on the register copies
    task automatic half(input logic [1:0] m, input logic st, tg, ps,
        input bit isy, output dxd_pkg::dxd_xy_req_t q);
        int p;
        q = '0;
        p = isy ? 6 + ps : 4 + ps;
        if (m != dxd_pkg::MODE_IDLE)
        begin
            q.addr = r[p];
            q.we = st;
            q.re = !st;
            if (st) q.wdata = d[4 + tg][31:16];
            if (st && isy) ym[q.addr] = q.wdata;
            if (st && !isy) xm[q.addr] = q.wdata;
            if (!st) d[(isy ? 2 : 0) + tg] = {mrd(isy, q.addr), 16'h0};
            if (m == dxd_pkg::MODE_INC) r[p] += 32'h2;
            if (m == dxd_pkg::MODE_INDEX) r[p] += r[isy ? 9 : 8];
        end
    endtask
    task automatic dbl(input logic [9:0] f, input bit par);
        dxd_note_t n;
        n = '0;
        t = lfsr();
        if (par) fb_last = t[15:0];
        n.plen = par;
        n.done = 1'b1;
        n.fb = fb_last;
        half(f[3:2], f[5], f[7], f[9], 1'b0, n.x);
        half(f[1:0], f[4], f[6], f[8], 1'b1, n.y);
        issue({par ? dxd_pkg::PARALLEL_PREFIX : dxd_pkg::DOUBLE_PREFIX, f,
            t[15:0]}, n, 1'b1);
    endtask
    task automatic single(input logic [3:0] m);
        dxd_note_t n;
        logic [3:0] scode [6];
        int p, i;
        scode = '{dxd_pkg::DS_X0, dxd_pkg::DS_X1, dxd_pkg::DS_Y0,
            dxd_pkg::DS_Y1, dxd_pkg::DS_A0, dxd_pkg::DS_A1};
        t = lfsr();
        i = t[7:0] % 6;
        p = t[9] ? 2 + t[8] : 4 + t[8];
        n = '0;
        n.done = 1'b1;
        n.fb = fb_last;
        n.s.long_size = m[1];
        n.s.we = m[0];
        n.s.re = !m[0];
        if (m[3:2] == 2'h0) r[p] -= m[1] ? 32'h4 : 32'h2;
        n.s.addr = r[p];
        if (m[3:2] == 2'h2) r[p] += m[1] ? 32'h4 : 32'h2;
        if (m[3:2] == 2'h3) r[p] += r[8];
        if (m[0]) n.s.wdata = m[1] ? d[i] : {16'h0, d[i][31:16]};
        else d[i] = m[1] ? t : {t[15:0], 16'h0};
        issue({dxd_pkg::SINGLE_PREFIX, t[9:8], scode[i], m, t[31:16]}, n, 1'b1);
        sbus_rdata = t;
        idle(2);
    endtask

    // Results are matched in order against what the driver noted
    initial
    forever
    begin
        @(posedge mclk);
        #2 cur = {xmem_req, ymem_req, sbus_req, parallel_len, xfer_done,
            xfer_bad, field_b};
        if (|{xmem_req.re, xmem_req.we, ymem_req.re, ymem_req.we, sbus_req.re,
            sbus_req.we, parallel_len, xfer_done, xfer_bad} !== 1'b0)
        begin
            ex = '0;
            if (notes.size() > 0) ex = notes.pop_front();
            check("result", cur, ex);
        end
    end

    initial
    begin
        #(40 * 3000);
        bad_count++;
        summarize();
    end

    initial
    begin
        {instr_valid, gr_we, dr_we, arst_n} = 4'h0;
        {instr_word, gr_wdata, dr_wdata, sbus_rdata} = 128'h0;
        {gr_widx, dr_widx} = 7'h0;
        fb_last = 16'h0;
        repeat (3) @(posedge mclk);
        #1 arst_n = 1'b1;
        for (int k = 2; k < 16; k++) wr(k[3:0], lfsr() & 32'hfffffffe, 1'b0);
        for (int k = 0; k < 6; k++) wr(k[3:0], lfsr(), 1'b1);
        issue(32'h30080000, '0, 1'b0);
        // Every X form against every Y form, parallel when f + g is odd, else standalone
        for (int f = 0; f < 7; f++)
            for (int g = 0; g < 7; g++)
            begin
                t = lfsr();
                a = {f > 0 && t[0], g > 0 && t[1], f > 0 && t[2], g > 0 && t[3],
                    f >= 4, g >= 4, f > 0 ? 2'((f - 1) % 3 + 1) : 2'h0,
                    g > 0 ? 2'((g - 1) % 3 + 1) : 2'h0};
                dbl(a, (f + g) % 2 == 1);
            end
        idle(3);
        for (int m = 0; m < 16; m++) single(m[3:0]);
        ex = '0;
        ex.bad = 1'b1;
        ex.fb = fb_last;
        issue({dxd_pkg::SINGLE_PREFIX, 10'h004, 16'h0}, ex, 1'b1);
        for (int i = 0; i < 5; i++)
        begin
            ex = '0;
            r[15] -= 32'h4;
            ex.s = {1'b0, 1'b1, 1'b1, r[15], d[i]};
            ex.done = 1'b1;
            ex.fb = fb_last;
            issue({dxd_pkg::SYS_STORE_TOP, 4'hf, i == 4 ? dxd_pkg::SYS_A0
                : 4'(dxd_pkg::SYS_X0 + i), dxd_pkg::SYS_STORE_LOW, 16'h0},
                ex, 1'b1);
        end
        idle(4);
        samples_checked++;
        if (notes.size() != 0)
        begin
            bad_count++;
            $display("unexpected pending: expected 0 seen %0d", notes.size());
        end
        summarize();
    end
endmodule

bind dxd_decode dxd_decode_sva i_sva (.mclk(mclk), .arst_n(arst_n),
    .instr_valid(instr_valid), .instr_word(instr_word), .gr_we(gr_we),
    .xmem_req(xmem_req), .ymem_req(ymem_req), .sbus_req(sbus_req),
    .parallel_len(parallel_len), .field_b(field_b), .xfer_done(xfer_done),
    .xfer_bad(xfer_bad));
